// >>> ext_irq3_input_and_timer_ctrl.sv
// External interrupt 3 input conditioning and the two shared timer control registers.
// Assumes synchronous pin inputs, timer datapath outside, word-addressed Avalon-MM slave.
`timescale 1ns/100ps
module ext_irq3_input_and_timer_ctrl (
	input  wire logic                      clk_sys_i,         // System clock, 20 MHz.
	input  wire logic                      srst_i,            // Synchronous reset, active high.
	input  wire logic [ext_irq3_pkg::ADDR_W-1:0] avs_address_i, // Word address.
	input  wire logic                      avs_read_i,        // Read request.
	input  wire logic                      avs_write_i,       // Write request.
	input  wire logic [31:0]               avs_writedata_i,   // Write data.
	input  wire logic [3:0]                avs_byteenable_i,  // Byte lanes.
	output logic [31:0]                    avs_readdata_o,    // Read data.
	output logic                           avs_waitrequest_o, // Stall while answer not ready.
	input  wire logic                      ext_irq_three_i,   // Interrupt 3 pin level.
	input  wire logic                      slow_osc_div128_i, // Divided slow oscillator level.
	input  wire logic                      fast_osc_clock_i,  // Fast oscillator tick, one cycle.
	input  wire logic                      cmp0_match_i,      // Compare 0 match pulse.
	input  wire logic                      cmp1_match_i,      // Compare 1 match pulse.
	output logic                           request_flag_o,    // Interrupt 3 request flag.
	output logic                           port3_bit3_level_o, // Raw pin level.
	output logic                           count_enable_o,    // Timer counts when high.
	output logic                           count_tick_o,      // Selected count source tick.
	output logic                           counter_clear_o,   // Clear counter to zero.
	output logic                           capture_mode_o,    // High in input capture mode.
	output logic                           compare_output_o   // Compare output level.
);
	import ext_irq3_pkg::*;

	typedef struct packed {
		logic [7:0]         ctrl_a;
		logic [7:0]         ctrl_b;
		logic               request_flag;
		logic               pending;
		logic               prev_level;
		logic               compare_output;
		logic [PRESC_W-1:0] presc;
		logic               pin_level;
		logic [31:0]        rdata;
		logic               ack;
		logic               armed;
	} ctl_state_t;

	ctl_state_t s;
	ctl_state_t next_s;

	logic       filtered;
	logic       filter_tick;
	logic       f8_tick;
	logic       f32_tick;
	logic       src_level;
	logic       filter_on;
	logic       det_level;
	logic       edge_hit;
	logic       source_tick;
	logic       immediate;
	logic       side_set;
	logic       flag_clr;
	logic       do_write;
	logic [7:0] wbyte;

	// ==========================================================================
	// Helpers
	// ==========================================================================
	// Picks one of four strobes; used for both the filter and the count source.
	function automatic logic pick_tick(input logic [3:0] ticks, input logic [1:0] sel);
		pick_tick = ticks[sel];
	endfunction

	function automatic logic [1:0] apply_cmp(input logic [1:0] mode, input logic cur);
		case (mode)
			CMP_TOGGLE: apply_cmp = {1'b0, ~cur};
			CMP_LOW:    apply_cmp = 2'h0;
			CMP_HIGH:   apply_cmp = 2'h1;
			default:    apply_cmp = {1'b0, cur};
		endcase
	endfunction

	// ==========================================================================
	// Prescaler strobes and source selection
	// ==========================================================================
	assign f8_tick     = (s.presc & F8_MASK) == F8_MASK;
	assign f32_tick    = s.presc == F32_MASK;
	assign filter_on   = s.ctrl_b[B_FILTER_LO +: 2] != 2'h0;
	assign filter_tick = pick_tick({f32_tick, f8_tick, 1'b1, 1'b0},
		s.ctrl_b[B_FILTER_LO +: 2]);
	assign source_tick = pick_tick({fast_osc_clock_i, f32_tick, f8_tick, 1'b1},
		s.ctrl_a[A_COUNT_SRC_LO +: 2]);
	assign src_level   = s.ctrl_a[A_SOURCE_SEL] ? slow_osc_div128_i
		: ext_irq_three_i;

	irq3_noise_filter u_filter (
		.clk_sys_i     (clk_sys_i),
		.srst_i        (srst_i),
		.sample_tick_i (filter_tick),
		.level_i       (src_level),
		.filtered_o    (filtered)
	);

	// The filter only moves on a sampling strobe, so its edges are already in step.
	assign det_level = filter_on ? filtered : src_level;

	// ==========================================================================
	// Edge detection and request timing
	// ==========================================================================
	always_comb begin
		case (s.ctrl_a[A_POLARITY_LO +: 2])
			POL_RISING:  edge_hit = det_level & ~s.prev_level;
			POL_FALLING: edge_hit = ~det_level & s.prev_level;
			POL_BOTH:    edge_hit = det_level ^ s.prev_level;
			default:     edge_hit = 1'b0;
		endcase
		// Right after reset the previous level is a reset value, not the pin, so a pin
		// idling high would otherwise raise a false rising edge.
		if (!s.armed) begin
			edge_hit = 1'b0;
		end
	end

	// Filter on, the timing select or compare mode bypasses the count-source wait.
	assign immediate = filter_on
		| s.ctrl_a[A_TIMING_SEL]
		| s.ctrl_b[B_CAPCMP_SEL];

	// ==========================================================================
	// Register bus
	// ==========================================================================
	// One wait state per access; the answer stands at the second edge.
	assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~s.ack;
	assign do_write = avs_write_i & s.ack & avs_byteenable_i[0];
	assign wbyte    = avs_writedata_i[7:0];
	assign flag_clr = do_write && avs_address_i == IDX_STATUS && wbyte[S_REQUEST_FLAG];
	// A change of polarity, timing or source can look like an input event.
	assign side_set = do_write && avs_address_i == IDX_CTRL_A
		&& (wbyte[7:3] != s.ctrl_a[7:3]);

	// ==========================================================================
	// Next state
	// ==========================================================================
	always_comb begin
		logic [1:0] cmp_v;
		cmp_v  = 2'h0;
		next_s = s;
		next_s.presc      = s.presc + 5'h01;
		next_s.prev_level = det_level;
		next_s.pin_level  = ext_irq_three_i;
		next_s.ack        = (avs_read_i | avs_write_i) & ~s.ack;
		next_s.armed      = 1'b1;

		if (edge_hit && !immediate) begin
			next_s.pending = 1'b1;
		end
		if (s.pending && source_tick) begin
			next_s.pending = 1'b0;
		end

		// Set wins over a software clear in the same cycle.
		next_s.request_flag = (s.request_flag & ~flag_clr) | side_set
			| (edge_hit & immediate) | (s.pending & source_tick);

		if (s.ctrl_b[B_CAPCMP_SEL]) begin
			if (cmp0_match_i) begin
				cmp_v = apply_cmp(s.ctrl_b[B_CMP0_MODE_LO +: 2], s.compare_output);
				next_s.compare_output = cmp_v[0];
			end
			if (cmp1_match_i) begin
				cmp_v = apply_cmp(s.ctrl_b[B_CMP1_MODE_LO +: 2],
					next_s.compare_output);
				next_s.compare_output = cmp_v[0];
			end
		end

		if (do_write && avs_address_i == IDX_CTRL_A) begin
			next_s.ctrl_a = wbyte;
		end
		if (do_write && avs_address_i == IDX_CTRL_B) begin
			next_s.ctrl_b = wbyte;
		end

		if (next_s.ack && avs_read_i) begin
			case (avs_address_i)
				IDX_CTRL_A: next_s.rdata = {24'h000000, s.ctrl_a};
				IDX_CTRL_B: next_s.rdata = {24'h000000, s.ctrl_b};
				IDX_STATUS: next_s.rdata = {27'h0000000, s.pending, filtered,
					s.compare_output, s.pin_level, s.request_flag};
				default:    next_s.rdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			s        <= '0;
			s.ctrl_a <= CTRL_A_RESET;
			s.ctrl_b <= CTRL_B_RESET;
		end else begin
			s <= next_s;
		end
	end

	// ==========================================================================
	// Timer control outputs
	// ==========================================================================
	assign count_enable_o     = s.ctrl_a[A_COUNT_RUN];
	assign count_tick_o       = s.ctrl_a[A_COUNT_RUN] & source_tick;
	assign counter_clear_o    = s.ctrl_b[B_RELOAD_SEL] & cmp1_match_i;
	assign capture_mode_o     = ~s.ctrl_b[B_CAPCMP_SEL];
	assign compare_output_o   = s.compare_output;
	assign request_flag_o     = s.request_flag;
	assign port3_bit3_level_o = s.pin_level;
	assign avs_readdata_o     = s.rdata;

endmodule

// >>> ext_irq3_pkg.sv
// Constants shared by the external interrupt 3 conditioning block.
// Assumes a single 20 MHz system clock and a word-addressed Avalon-MM slave.
package ext_irq3_pkg;

	// ==========================================================================
	// Clock and register map
	// ==========================================================================
	localparam int          CLK_HZ            = 20_000_000;
	localparam int          ADDR_W            = 8;
	localparam logic [7:0]  IDX_CTRL_A        = 8'h9a;
	localparam logic [7:0]  IDX_CTRL_B        = 8'h9b;
	localparam logic [7:0]  IDX_STATUS        = 8'h9c;
	localparam logic [7:0]  CTRL_A_RESET      = 8'h00;
	localparam logic [7:0]  CTRL_B_RESET      = 8'h00;

	// ==========================================================================
	// Field positions of capture_timer_control_a
	// ==========================================================================
	localparam int          A_COUNT_RUN       = 0;
	localparam int          A_COUNT_SRC_LO    = 1;
	localparam int          A_POLARITY_LO     = 3;
	localparam int          A_TIMING_SEL      = 6;
	localparam int          A_SOURCE_SEL      = 7;

	// ==========================================================================
	// Field positions of capture_timer_control_b
	// ==========================================================================
	localparam int          B_FILTER_LO       = 0;
	localparam int          B_RELOAD_SEL      = 2;
	localparam int          B_CAPCMP_SEL      = 3;
	localparam int          B_CMP0_MODE_LO    = 4;
	localparam int          B_CMP1_MODE_LO    = 6;

	// ==========================================================================
	// Status register bits
	// ==========================================================================
	localparam int          S_REQUEST_FLAG    = 0;
	localparam int          S_PIN_LEVEL       = 1;
	localparam int          S_COMPARE_OUT     = 2;
	localparam int          S_FILTERED        = 3;
	localparam int          S_PENDING         = 4;

	// ==========================================================================
	// Encodings and prescaler counts
	// ==========================================================================
	localparam logic [1:0]  POL_RISING        = 2'h0;
	localparam logic [1:0]  POL_FALLING       = 2'h1;
	localparam logic [1:0]  POL_BOTH          = 2'h2;
	localparam logic [1:0]  CMP_KEEP          = 2'h0;
	localparam logic [1:0]  CMP_TOGGLE        = 2'h1;
	localparam logic [1:0]  CMP_LOW           = 2'h2;
	localparam logic [1:0]  CMP_HIGH          = 2'h3;
	localparam int          PRESC_W           = 5;
	localparam logic [4:0]  F8_MASK           = 5'h07;
	localparam logic [4:0]  F32_MASK          = 5'h1f;
	localparam logic [1:0]  FILTER_AGREE_LAST = 2'h2;

endpackage

// >>> irq3_noise_filter.sv
// Three-sample agreement filter for the interrupt 3 input level.
// Assumes the sample strobe is a one-cycle pulse in the system clock domain.
`timescale 1ns/100ps
module irq3_noise_filter (
	input  wire logic clk_sys_i,     // System clock.
	input  wire logic srst_i,        // Synchronous reset, active high.
	input  wire logic sample_tick_i, // Sampling strobe, one cycle.
	input  wire logic level_i,       // Level to be filtered.
	output logic      filtered_o     // Level accepted after agreement.
);
	import ext_irq3_pkg::*;

	typedef struct packed {
		logic [1:0] agree_cnt;
		logic       last_sample;
		logic       filtered;
	} filt_state_t;

	filt_state_t s;
	filt_state_t next_s;

	// ==========================================================================
	// Agreement counting
	// ==========================================================================
	always_comb begin
		next_s = s;
		if (sample_tick_i) begin
			next_s.last_sample = level_i;
			if (level_i != s.last_sample) begin
				next_s.agree_cnt = 2'h0;
			end else if (s.agree_cnt != FILTER_AGREE_LAST) begin
				next_s.agree_cnt = s.agree_cnt + 2'h1;
			end
			// The third equal sample in a row moves the output.
			if (level_i == s.last_sample && s.agree_cnt >= FILTER_AGREE_LAST - 2'h1) begin
				next_s.filtered = level_i;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign filtered_o = s.filtered;

endmodule

// >>> ext_irq3_pin_model.sv
// Far-side model: the interrupt 3 pin and the divided slow oscillator level.
// Assumes the bench calls set_levels and that both lines are synchronous.
`timescale 1ns/100ps
module ext_irq3_pin_model (
	input  wire logic clk_sys_i, // System clock.
	output logic      pin_o,     // Interrupt 3 pin level.
	output logic      osc_o      // Divided slow oscillator level.
);
	initial begin
		pin_o = 1'b0;
		osc_o = 1'b0;
	end
	// Levels move just after a rising edge so the block never samples a changing line.
	task automatic set_levels(input logic pin, input logic osc);
		@(posedge clk_sys_i);
		pin_o <= pin;
		osc_o <= osc;
	endtask
endmodule

// >>> ext_irq3_input_and_timer_ctrl_chk.sv
// Port checker for the interrupt 3 block, bound to its top module.
// Assumes register writes land at the edge where waitrequest is low.
`timescale 1ns/100ps
module ext_irq3_input_and_timer_ctrl_chk
	import ext_irq3_pkg::*;
(
	input wire logic        clk_sys_i,          // Clock.
	input wire logic        srst_i,             // Reset.
	input wire logic [7:0]  avs_address_i,      // Address.
	input wire logic        avs_read_i,         // Read.
	input wire logic        avs_write_i,        // Write.
	input wire logic [31:0] avs_writedata_i,    // Write data.
	input wire logic [3:0]  avs_byteenable_i,   // Lanes.
	input wire logic        avs_waitrequest_o,  // Stall.
	input wire logic        ext_irq_three_i,    // Pin.
	input wire logic        cmp0_match_i,       // Match 0.
	input wire logic        cmp1_match_i,       // Match 1.
	input wire logic        request_flag_o,     // Flag.
	input wire logic        port3_bit3_level_o, // Raw level.
	input wire logic        count_enable_o,     // Run.
	input wire logic        count_tick_o,       // Tick.
	input wire logic        counter_clear_o,    // Clear.
	input wire logic        capture_mode_o,     // Capture mode.
	input wire logic        compare_output_o    // Compare out.
);
	logic [7:0] ctl_a;
	logic [7:0] ctl_b;
	wire        wr_done = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
	// Shadow copies let the properties know the mode without peeking inside.
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			ctl_a <= 8'h00;
			ctl_b <= 8'h00;
		end else if (wr_done && avs_address_i == IDX_CTRL_A) begin
			ctl_a <= avs_writedata_i[7:0];
		end else if (wr_done && avs_address_i == IDX_CTRL_B) begin
			ctl_b <= avs_writedata_i[7:0];
		end
	end
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);
	sequence rise_s;
		!ext_irq_three_i ##1 ext_irq_three_i;
	endsequence
	sequence glitch_s;
		!ext_irq_three_i [*3] ##1 ext_irq_three_i [*2] ##1 !ext_irq_three_i;
	endsequence
	a_wait_one: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
		|=> !avs_waitrequest_o) else $error("waitrequest too long");
	a_run_level: assert property (count_enable_o == ctl_a[A_COUNT_RUN])
		else $error("count enable wrong");
	a_f1_tick: assert property (count_enable_o && ctl_a[2:1] == 2'h0 |-> count_tick_o)
		else $error("f1 tick missing");
	a_reload_clear: assert property (counter_clear_o == (ctl_b[2] && cmp1_match_i))
		else $error("counter clear wrong");
	a_mode_level: assert property (capture_mode_o == !ctl_b[B_CAPCMP_SEL])
		else $error("capture mode wrong");
	a_raw_level: assert property (!$past(srst_i) |->
		port3_bit3_level_o == $past(ext_irq_three_i)) else $error("raw level wrong");
	a_out_cause: assert property (!$past(srst_i) && $changed(compare_output_o) |->
		$past(cmp0_match_i || cmp1_match_i)) else $error("compare out moved");
	a_cmp1_high: assert property (!capture_mode_o && ctl_b[7:6] == CMP_HIGH
		&& cmp1_match_i |=> compare_output_o) else $error("compare 1 high");
	a_cmp0_low: assert property (!capture_mode_o && ctl_b[5:4] == CMP_LOW
		&& cmp0_match_i && !cmp1_match_i |=> !compare_output_o) else $error("compare 0 low");
	a_flag_hold: assert property (request_flag_o
		&& !(wr_done && avs_address_i == IDX_STATUS && avs_writedata_i[0])
		|=> request_flag_o) else $error("flag dropped");
	a_edge_flag: assert property (ctl_a[7:6] == 2'h1 && ctl_a[4:3] == POL_RISING
		&& ctl_b[1:0] == 2'h0 ##0 rise_s |-> ##[1:3] request_flag_o) else $error("no flag");
	// The flag is looked at when the glitch ends, since a clear often lands during it.
	a_glitch_off: assert property (ctl_b[1:0] == 2'h1 && ctl_a[4:3] == POL_RISING
		##0 glitch_s ##0 !request_flag_o |=> !request_flag_o [*4]) else $error("glitch");
endmodule
bind ext_irq3_input_and_timer_ctrl ext_irq3_input_and_timer_ctrl_chk chk_i (
	.clk_sys_i(clk_sys_i), .srst_i(srst_i), .avs_address_i(avs_address_i),
	.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
	.avs_byteenable_i(avs_byteenable_i), .avs_waitrequest_o(avs_waitrequest_o),
	.ext_irq_three_i(ext_irq_three_i), .cmp0_match_i(cmp0_match_i),
	.cmp1_match_i(cmp1_match_i), .request_flag_o(request_flag_o),
	.port3_bit3_level_o(port3_bit3_level_o), .count_enable_o(count_enable_o),
	.count_tick_o(count_tick_o), .counter_clear_o(counter_clear_o),
	.capture_mode_o(capture_mode_o), .compare_output_o(compare_output_o));

// >>> ext_irq3_input_and_timer_ctrl_tb.sv
// Self-checking bench for the interrupt 3 block over its Avalon-MM registers.
// Assumes the pin model and the bound checker are compiled alongside.
`timescale 1ns/100ps
module ext_irq3_input_and_timer_ctrl_tb;
	import ext_irq3_pkg::*;
	logic        clk_sys_i = 1'b0;
	logic        srst_i = 1'b1;
	logic [7:0]  avs_address_i = 8'h00;
	logic        avs_read_i = 1'b0;
	logic        avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [3:0]  avs_byteenable_i = 4'hf;
	logic        fast_osc_clock_i = 1'b0;
	logic        cmp0_match_i = 1'b0;
	logic        cmp1_match_i = 1'b0;
	logic [31:0] avs_readdata_o;
	logic        avs_waitrequest_o, ext_irq_three_i, slow_osc_div128_i, request_flag_o;
	logic        port3_bit3_level_o, count_enable_o, count_tick_o, counter_clear_o;
	logic        capture_mode_o, compare_output_o;
	int          err_count = 0;
	int          samples_checked = 0;
	int          n;
	int          tick_exp[4] = '{64, 8, 2, 16};
	int          fw[7] = '{1, 2, 4, 12, 40, 60, 120};
	logic [1:0]  fsel[7] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
	logic        fexp[7] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1};
	initial forever #25 clk_sys_i = ~clk_sys_i;
	ext_irq3_pin_model pin (.clk_sys_i(clk_sys_i), .pin_o(ext_irq_three_i),
		.osc_o(slow_osc_div128_i));
	ext_irq3_input_and_timer_ctrl ext_irq3_input_and_timer_ctrl_i (
		.clk_sys_i(clk_sys_i), .srst_i(srst_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .ext_irq_three_i(ext_irq_three_i),
		.slow_osc_div128_i(slow_osc_div128_i), .fast_osc_clock_i(fast_osc_clock_i),
		.cmp0_match_i(cmp0_match_i), .cmp1_match_i(cmp1_match_i),
		.request_flag_o(request_flag_o), .port3_bit3_level_o(port3_bit3_level_o),
		.count_enable_o(count_enable_o), .count_tick_o(count_tick_o),
		.counter_clear_o(counter_clear_o), .capture_mode_o(capture_mode_o),
		.compare_output_o(compare_output_o));
	// ==========================================================================
	// Tasks
	// ==========================================================================
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Waitrequest is sampled at the rising edge; at that edge the write lands and the
	// read data are taken, and only then is the request released.
	task automatic acc(input logic wr, input logic [7:0] ad, input logic [31:0] wd,
		output logic [31:0] rd);
		int k;
		@(posedge clk_sys_i);
		avs_address_i <= ad;
		avs_writedata_i <= wd;
		avs_read_i <= !wr;
		avs_write_i <= wr;
		for (k = 0; k < 20; k++) begin
			@(posedge clk_sys_i);
			if (avs_waitrequest_o === 1'b0) break;
		end
		if (k < 20) begin
			rd = avs_readdata_o;
			avs_read_i <= 1'b0;
			avs_write_i <= 1'b0;
		end else begin
			err_count++;
			finish_test();
		end
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
		logic [31:0] x;
		acc(1'b1, ad, wd, x);
	endtask
	task automatic rd(input logic [7:0] ad, input logic [31:0] exp);
		logic [31:0] x;
		acc(1'b0, ad, 32'h0, x);
		chk("register read", exp, x);
	endtask
	task automatic cyc(input int c);
		repeat (c) @(posedge clk_sys_i);
	endtask
	task automatic flag_is(input logic exp);
		@(negedge clk_sys_i);
		chk("request flag", {31'h0, exp}, {31'h0, request_flag_o});
	endtask
	task automatic match(input logic m0, input logic m1, input logic out, input logic cl);
		@(posedge clk_sys_i);
		cmp0_match_i <= m0;
		cmp1_match_i <= m1;
		@(negedge clk_sys_i);
		chk("counter clear", {31'h0, cl}, {31'h0, counter_clear_o});
		@(posedge clk_sys_i);
		cmp0_match_i <= 1'b0;
		cmp1_match_i <= 1'b0;
		@(negedge clk_sys_i);
		chk("compare output", {31'h0, out}, {31'h0, compare_output_o});
	endtask
	// ==========================================================================
	// Sequence
	// ==========================================================================
	initial begin
		repeat (5) @(posedge clk_sys_i);
		srst_i <= 1'b0;
		rd(IDX_CTRL_A, 32'h0);
		rd(IDX_CTRL_B, 32'h0);
		wr(8'h10, 32'hff);
		rd(8'h10, 32'h0);
		avs_byteenable_i <= 4'he;
		wr(IDX_CTRL_B, 32'hff);
		avs_byteenable_i <= 4'hf;
		rd(IDX_CTRL_B, 32'h0);
		for (int s = 0; s < 4; s++) begin
			for (int r = 0; r < 2; r++) begin
				wr(IDX_CTRL_A, 32'(s << 1 | r));
				n = 0;
				for (int i = 0; i < 64; i++) begin
					@(posedge clk_sys_i);
					fast_osc_clock_i <= (i % 4 == 0);
					@(negedge clk_sys_i);
					n += (count_tick_o === 1'b1);
				end
				chk("count ticks", r * tick_exp[s], n);
			end
			wr(IDX_CTRL_A, 32'(s << 1));
		end
		fast_osc_clock_i <= 1'b0;
		wr(IDX_CTRL_A, 32'h08);
		flag_is(1'b1);
		for (int p = 0; p < 4; p++) begin
			wr(IDX_CTRL_A, 32'(8'h40 | p << 3));
			wr(IDX_STATUS, 32'h1);
			pin.set_levels(1'b1, 1'b0);
			cyc(4);
			flag_is(p == 0 || p == 2);
			wr(IDX_STATUS, 32'h1);
			pin.set_levels(1'b0, 1'b0);
			cyc(4);
			flag_is(p == 1 || p == 2);
		end
		wr(IDX_CTRL_A, 32'hd0);
		wr(IDX_STATUS, 32'h1);
		pin.set_levels(1'b1, 1'b0);
		cyc(4);
		flag_is(1'b0);
		pin.set_levels(1'b1, 1'b1);
		cyc(4);
		flag_is(1'b1);
		wr(IDX_STATUS, 32'h1);
		pin.set_levels(1'b0, 1'b0);
		cyc(4);
		flag_is(1'b1);
		wr(IDX_CTRL_A, 32'h06);
		wr(IDX_STATUS, 32'h1);
		pin.set_levels(1'b1, 1'b0);
		cyc(8);
		flag_is(1'b0);
		rd(IDX_STATUS, 32'h12);
		@(posedge clk_sys_i) fast_osc_clock_i <= 1'b1;
		@(posedge clk_sys_i) fast_osc_clock_i <= 1'b0;
		cyc(2);
		flag_is(1'b1);
		pin.set_levels(1'b0, 1'b0);
		wr(IDX_CTRL_B, 32'h08);
		wr(IDX_STATUS, 32'h1);
		pin.set_levels(1'b1, 1'b0);
		cyc(4);
		flag_is(1'b1);
		rd(IDX_STATUS, 32'h03);
		pin.set_levels(1'b0, 1'b0);
		wr(IDX_CTRL_B, 32'hdc);
		rd(IDX_CTRL_B, 32'hdc);
		match(1'b0, 1'b1, 1'b1, 1'b1);
		match(1'b1, 1'b0, 1'b0, 1'b0);
		match(1'b1, 1'b1, 1'b1, 1'b1);
		wr(IDX_CTRL_B, 32'h68);
		match(1'b1, 1'b0, 1'b0, 1'b0);
		match(1'b0, 1'b1, 1'b1, 1'b0);
		wr(IDX_CTRL_B, 32'h88);
		match(1'b1, 1'b0, 1'b1, 1'b0);
		match(1'b0, 1'b1, 1'b0, 1'b0);
		wr(IDX_CTRL_B, 32'h38);
		match(1'b0, 1'b1, 1'b0, 1'b0);
		match(1'b1, 1'b0, 1'b1, 1'b0);
		wr(IDX_CTRL_B, 32'h00);
		match(1'b1, 1'b1, 1'b1, 1'b0);
		chk("capture mode", 32'h1, {31'h0, capture_mode_o});
		wr(IDX_CTRL_A, 32'h40);
		for (int k = 0; k < 7; k++) begin
			wr(IDX_CTRL_B, {30'h0, fsel[k]});
			wr(IDX_STATUS, 32'h1);
			pin.set_levels(1'b1, 1'b0);
			cyc(fw[k] - 1);
			pin.set_levels(1'b0, 1'b0);
			cyc(130);
			flag_is(fexp[k]);
		end
		finish_test();
	end
endmodule
